// ===== pkg/xfer_pkg.sv
package xfer_pkg;

   // instruction classes presented by the fetch/decode stage
   typedef enum logic [4:0] {
      op_nop,
      op_indirect_load,
      op_displaced_load,
      op_direct_load,
      op_indirect_store,
      op_displaced_store,
      op_direct_store,
      op_program_memory_read,
      op_program_memory_write,
      op_io_in,
      op_io_out,
      op_push,
      op_pop,
      op_sleep,
      op_watchdog_restart,
      op_break
   } xfer_op_e;

   // pointer pair select: first, second, third
   localparam logic [1:0] PTR_FIRST  = 2'h0;
   localparam logic [1:0] PTR_SECOND = 2'h1;
   localparam logic [1:0] PTR_THIRD  = 2'h2;

   // addressing mode of the indirect forms
   localparam logic [1:0] MODE_PLAIN = 2'h0;
   localparam logic [1:0] MODE_POST  = 2'h1;
   localparam logic [1:0] MODE_PRE   = 2'h2;

   localparam int unsigned ADDR_W     = 16;
   localparam int unsigned DISP_W     = 6;
   localparam int unsigned REG_IDX_W  = 5;
   localparam int unsigned IO_ADDR_W  = 6;

   localparam logic [4:0]  REG_ZERO   = 5'h00;
   localparam logic [15:0] PTR_RESET  = 16'h0000;
   localparam logic [15:0] SP_RESET   = 16'h08ff;

   // cycle counts per class
   localparam logic [1:0] CYC_DATA = 2'h2;
   localparam logic [1:0] CYC_PROG = 2'h3;
   localparam logic [1:0] CYC_ONE  = 2'h1;

endpackage : xfer_pkg

// ===== src/data_transfer_instruction_unit.sv
`timescale 1ns/10ps
// Summary of operation
// - pre-decrement load: decrement, then load, 2 cycles
// - post-increment load: load, then increment, 2 cycles
// - displaced load: pointer plus offset, 2 cycles
// - direct load from instruction address, 2 cycles
// - post-increment store: write, then increment, 2 cycles
// - pre-decrement store: decrement, then write, 2 cycles
// - displaced store: pointer plus offset, 2 cycles
// - direct store to instruction address, 2 cycles
// - program read via third pointer, 3 cycles
// - I/O in and out in 1 cycle
// - push source register, 2 cycles
// - pop into destination register, 2 cycles
// - sleep: 1 cycle, signal sleep function
// - watchdog restart: 1 cycle, restart pulse
// - break acts only for on-chip debug
module data_transfer_instruction_unit
   import xfer_pkg::*;
(
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_rst_b,
   // instruction issue
   input  wire logic                 i_start,
   input  wire xfer_op_e             i_op,
   input  wire logic [1:0]           i_ptr_sel,
   input  wire logic [1:0]           i_mode,
   input  wire logic [5:0]           i_disp,
   input  wire logic [15:0]          i_direct_addr,
   input  wire logic [5:0]           i_io_addr,
   input  wire logic [4:0]           i_reg_idx,
   input  wire logic [7:0]           i_source_register,
   input  wire logic [15:0]          i_word_pair,
   input  wire logic                 i_debug_enable,
   output logic                      o_busy,
   output logic                      o_done,
   // register file write-back
   output logic                      o_rf_we,
   output logic [4:0]                o_rf_idx,
   output logic [7:0]                o_rf_data,
   // data memory
   output logic                      o_dm_re,
   output logic                      o_dm_we,
   output logic [15:0]               o_dm_addr,
   output logic [7:0]                o_dm_wdata,
   input  wire logic [7:0]           i_dm_rdata,
   // program memory
   output logic                      o_pm_re,
   output logic                      o_pm_we,
   output logic [15:0]               o_pm_addr,
   output logic [15:0]               o_pm_wdata,
   input  wire logic [7:0]           i_pm_rdata,
   input  wire logic                 i_pm_write_done,
   // I/O space
   output logic                      o_io_re,
   output logic                      o_io_we,
   output logic [5:0]                o_io_addr,
   output logic [7:0]                o_io_wdata,
   input  wire logic [7:0]           i_io_rdata,
   // processor control
   output logic                      o_sleep_req,
   output logic                      o_watchdog_restart,
   output logic                      o_break_req,
   output logic [15:0]               o_ptr_first,
   output logic [15:0]               o_ptr_second,
   output logic [15:0]               o_ptr_third,
   output logic [15:0]               o_stack_ptr
);

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      st_idle,
      st_access,
      st_finish,
      st_pm_wait
   } phase_e;

   typedef struct packed {
      phase_e      phase;
      xfer_op_e    op;
      logic [1:0]  ptr_sel;
      logic [1:0]  mode;
      logic [4:0]  reg_idx;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [15:0] sp;
      logic        done;
      logic        rf_we;
      logic [7:0]  rf_data;
      logic        sleep_req;
      logic        wd_restart;
      logic        break_req;
   } unit_state_s;

   unit_state_s state;
   unit_state_s next_state;

   logic [2:0]  ptr_inc;
   logic [2:0]  ptr_dec;
   logic [15:0] ptr_val [3];
   logic [15:0] sel_ptr;

   ////////////////////////////////////////////////////////////////////////////
   // pointer pairs as whole 16-bit words
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : gen_ptr
         pointer_pair u_ptr (
            .i_sys_clk    (i_sys_clk),
            .i_rst_b      (i_rst_b),
            .i_inc        (ptr_inc[g]),
            .i_dec        (ptr_dec[g]),
            .i_load       (1'b0),
            .i_load_value (PTR_RESET),
            .o_value      (ptr_val[g])
         );
      end
   endgenerate

   always_comb
   begin
      case (i_ptr_sel)
         PTR_FIRST:  sel_ptr = ptr_val[0];
         PTR_SECOND: sel_ptr = ptr_val[1];
         default:    sel_ptr = ptr_val[2];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // cycle 1 computes the address (and pre-decrement), cycle 2 accesses memory
   always_comb
   begin
      next_state            = state;
      next_state.done       = 1'b0;
      next_state.rf_we      = 1'b0;
      next_state.sleep_req  = 1'b0;
      next_state.wd_restart = 1'b0;
      next_state.break_req  = 1'b0;
      ptr_inc               = 3'h0;
      ptr_dec               = 3'h0;
      case (state.phase)
         st_idle:
         begin
            if (i_start)
            begin
               next_state.op      = i_op;
               next_state.ptr_sel = i_ptr_sel;
               next_state.mode    = i_mode;
               next_state.reg_idx = i_reg_idx;
               next_state.wdata   = i_source_register;
               case (i_op)
                  op_indirect_load, op_indirect_store:
                  begin
                     if (i_mode == MODE_PRE)
                     begin
                        // address is the decremented pointer
                        next_state.addr = sel_ptr - 16'h0001;
                        ptr_dec[i_ptr_sel] = 1'b1;
                     end
                     else
                     begin
                        next_state.addr = sel_ptr;
                     end
                     next_state.phase = st_access;
                  end
                  op_displaced_load, op_displaced_store:
                  begin
                     // only second/third pointers carry a displacement
                     next_state.addr  = ((i_ptr_sel == PTR_SECOND) ? ptr_val[1] : ptr_val[2])
                                        + {10'h000, i_disp};
                     next_state.phase = st_access;
                  end
                  op_direct_load, op_direct_store:
                  begin
                     next_state.addr  = i_direct_addr;
                     next_state.phase = st_access;
                  end
                  op_push:
                  begin
                     next_state.addr  = state.sp;
                     next_state.sp    = state.sp - 16'h0001;
                     next_state.phase = st_access;
                  end
                  op_pop:
                  begin
                     next_state.sp    = state.sp + 16'h0001;
                     next_state.addr  = state.sp + 16'h0001;
                     next_state.phase = st_access;
                  end
                  op_program_memory_read:
                  begin
                     next_state.addr    = ptr_val[2];
                     next_state.ptr_sel = PTR_THIRD;
                     next_state.phase   = st_access;
                  end
                  op_program_memory_write:
                  begin
                     next_state.addr  = ptr_val[2];
                     next_state.phase = st_pm_wait;
                  end
                  op_io_in:
                  begin
                     next_state.rf_we   = 1'b1;
                     next_state.rf_data = i_io_rdata;
                     next_state.done    = 1'b1;
                  end
                  op_io_out:
                  begin
                     next_state.done = 1'b1;
                  end
                  op_sleep:
                  begin
                     next_state.sleep_req = 1'b1;
                     next_state.done      = 1'b1;
                  end
                  op_watchdog_restart:
                  begin
                     next_state.wd_restart = 1'b1;
                     next_state.done       = 1'b1;
                  end
                  op_break:
                  begin
                     next_state.break_req = i_debug_enable;
                     next_state.done      = 1'b1;
                  end
                  default:
                  begin
                     next_state.done = 1'b1;
                  end
               endcase
            end
         end
         st_access:
         begin
            if (state.op == op_program_memory_read)
            begin
               // third cycle for program memory latency
               next_state.phase = st_finish;
            end
            else
            begin
               case (state.op)
                  op_indirect_load, op_displaced_load, op_direct_load, op_pop:
                  begin
                     next_state.rf_we   = 1'b1;
                     next_state.rf_data = i_dm_rdata;
                  end
                  default:
                  begin
                     next_state.rf_we = 1'b0;
                  end
               endcase
               if ((state.op == op_indirect_load || state.op == op_indirect_store) && state.mode == MODE_POST)
               begin
                  ptr_inc[state.ptr_sel] = 1'b1;
               end
               next_state.done  = 1'b1;
               next_state.phase = st_idle;
            end
         end
         st_finish:
         begin
            next_state.rf_we   = 1'b1;
            next_state.rf_data = i_pm_rdata;
            if (state.mode == MODE_POST)
            begin
               ptr_inc[2] = 1'b1;
            end
            next_state.done  = 1'b1;
            next_state.phase = st_idle;
         end
         st_pm_wait:
         begin
            // duration set by the memory, not by this unit
            if (i_pm_write_done)
            begin
               next_state.done  = 1'b1;
               next_state.phase = st_idle;
            end
         end
         default:
         begin
            next_state.phase = st_idle;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state <= '{phase: st_idle, op: op_nop, sp: SP_RESET, default: '0};
      end
      else
      begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // no status-flag port at all: nothing here can touch flags
   logic in_access;
   assign in_access = (state.phase == st_access);

   assign o_busy             = (state.phase != st_idle);
   assign o_done             = state.done;
   assign o_rf_we            = state.rf_we;
   assign o_rf_idx           = state.reg_idx;
   assign o_rf_data          = state.rf_data;
   assign o_dm_re            = in_access && (state.op == op_indirect_load || state.op == op_displaced_load
                                || state.op == op_direct_load || state.op == op_pop);
   assign o_dm_we            = in_access && (state.op == op_indirect_store || state.op == op_displaced_store
                                || state.op == op_direct_store || state.op == op_push);
   assign o_dm_addr          = state.addr;
   assign o_dm_wdata         = state.wdata;
   assign o_pm_re            = in_access && (state.op == op_program_memory_read);
   assign o_pm_we            = (state.phase == st_pm_wait);
   assign o_pm_addr          = state.addr;
   assign o_pm_wdata         = i_word_pair;
   assign o_io_re            = (state.phase == st_idle) && i_start && (i_op == op_io_in);
   assign o_io_we            = (state.phase == st_idle) && i_start && (i_op == op_io_out);
   assign o_io_addr          = i_io_addr;
   assign o_io_wdata         = i_source_register;
   assign o_sleep_req        = state.sleep_req;
   assign o_watchdog_restart = state.wd_restart;
   assign o_break_req        = state.break_req;
   assign o_ptr_first        = ptr_val[0];
   assign o_ptr_second       = ptr_val[1];
   assign o_ptr_third        = ptr_val[2];
   assign o_stack_ptr        = state.sp;

endmodule : data_transfer_instruction_unit

// ===== src/pointer_pair.sv
`timescale 1ns/10ps
// one 16-bit pointer pair, stepped as a whole word
module pointer_pair
   import xfer_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst_b,
   input  wire logic              i_inc,
   input  wire logic              i_dec,
   input  wire logic              i_load,
   input  wire logic [15:0]       i_load_value,
   output logic      [15:0]       o_value
);

   typedef struct packed {
      logic [15:0] value;
   } ptr_state_s;

   ptr_state_s state;
   ptr_state_s next_state;

   always_comb
   begin
      next_state = state;
      if (i_load)
      begin
         next_state.value = i_load_value;
      end
      else if (i_inc)
      begin
         next_state.value = state.value + 16'h0001;
      end
      else if (i_dec)
      begin
         next_state.value = state.value - 16'h0001;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state <= '{value: PTR_RESET};
      end
      else
      begin
         state <= next_state;
      end
   end

   assign o_value = state.value;

endmodule : pointer_pair

// ===== tb/data_transfer_instruction_unit_test.sv
`timescale 1ns/10ps
module data_transfer_instruction_unit_test import xfer_pkg::*;;
   logic        i_sys_clk = 1'b0, i_rst_b = 1'b0, i_start = 1'b0, i_debug_enable = 1'b0;
   xfer_op_e    i_op = op_nop;
   logic [1:0]  i_ptr_sel = 2'h0, i_mode = 2'h0;
   logic [5:0]  i_disp = 6'h00, i_io_addr = 6'h00, o_io_addr;
   logic [4:0]  i_reg_idx = 5'h00, o_rf_idx, ridx;
   logic [7:0]  i_source_register = 8'h00, i_dm_rdata, i_pm_rdata, i_io_rdata, o_rf_data, o_dm_wdata, o_io_wdata;
   logic [15:0] i_direct_addr = 16'h0000, i_word_pair = 16'h0000, o_dm_addr, o_pm_addr, o_pm_wdata;
   logic [15:0] o_ptr_first, o_ptr_second, o_ptr_third, o_stack_ptr, ad, pw;
   logic [7:0]  rf, wd;
   logic        o_busy, o_done, o_rf_we, o_dm_re, o_dm_we, o_pm_re, o_pm_we, o_io_re, o_io_we, i_pm_write_done;
   logic        o_sleep_req, o_watchdog_restart, o_break_req, sl, wr, br;
   logic [3:0]  wdel = 4'h0;
   int          n_fail = 0, n_checks = 0, cyc = 0, tick = 0;
   data_transfer_instruction_unit dut (.*);
   mem_model mem (
      .i_sys_clk, .i_dm_re(o_dm_re), .i_dm_we(o_dm_we), .i_dm_addr(o_dm_addr), .i_dm_wdata(o_dm_wdata),
      .o_dm_rdata(i_dm_rdata), .i_pm_re(o_pm_re), .i_pm_we(o_pm_we), .i_pm_addr(o_pm_addr),
      .o_pm_rdata(i_pm_rdata), .o_pm_write_done(i_pm_write_done), .i_wr_delay(wdel), .i_io_re(o_io_re),
      .i_io_we(o_io_we), .i_io_addr(o_io_addr), .i_io_wdata(o_io_wdata), .o_io_rdata(i_io_rdata)
   );
   initial forever #2 i_sys_clk = ~i_sys_clk;
   ////////////////////////////////////////
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task chk(input logic [15:0] g, e);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // called at a falling edge; returns at the falling edge where done is seen, or one falling edge later for one-cycle ops
   task issue(input xfer_op_e op, input logic [1:0] ps, md, input logic [15:0] a, input logic [7:0] s);
      i_start = 1'b1;
      i_op = op;
      i_ptr_sel = ps;
      i_mode = md;
      i_disp = a[5:0];
      i_io_addr = a[5:0];
      i_direct_addr = a;
      i_source_register = s;
      i_reg_idx = s[4:0];
      cyc = 1;
      @(negedge i_sys_clk);
      i_start = 1'b0;
      while (o_done !== 1'b1 && cyc < 30)
      begin
         if (o_dm_re || o_dm_we)
         begin
            ad = o_dm_addr;
            wd = o_dm_wdata;
         end
         if (o_pm_we) pw = o_pm_wdata;
         @(negedge i_sys_clk);
         cyc++;
      end
      chk(16'(o_done), 16'h0001);
      rf = o_rf_data;
      ridx = o_rf_idx;
      sl = o_sleep_req;
      wr = o_watchdog_restart;
      br = o_break_req;
      // one-cycle ops dropped start at this edge, so let it pass
      if (cyc == 1) @(negedge i_sys_clk);
   endtask : issue
   ////////////////////////////////////////
   task t_pointers;
      chk(o_stack_ptr, SP_RESET);
      chk(o_ptr_first, PTR_RESET);
      issue(op_indirect_store, PTR_FIRST, MODE_PRE, 16'h0000, 8'h96);
      chk(ad, 16'hffff);
      chk(o_ptr_first, 16'hffff);
      chk(16'(cyc), 16'(CYC_DATA));
      issue(op_indirect_load, PTR_FIRST, MODE_POST, 16'h0000, 8'h05);
      chk(rf, 8'h96);
      chk(o_ptr_first, 16'h0000);
      chk(ridx, 5'h05);
      issue(op_indirect_store, PTR_SECOND, MODE_POST, 16'h0000, 8'h3b);
      chk(ad, 16'h0000);
      chk(o_ptr_second, 16'h0001);
      issue(op_indirect_load, PTR_SECOND, MODE_PRE, 16'h0000, 8'h0a);
      chk(rf, 8'h3b);
      chk(o_ptr_second, 16'h0000);
      issue(op_indirect_load, PTR_SECOND, MODE_POST, 16'h0000, 8'h0b);
      chk(o_ptr_second, 16'h0001);
      $display("pointer forms finished");
   endtask : t_pointers
   task t_offsets;
      issue(op_displaced_store, PTR_SECOND, MODE_PLAIN, 16'h003f, 8'hc7);
      chk(ad, 16'h0040);
      issue(op_displaced_store, PTR_THIRD, MODE_PLAIN, 16'h003f, 8'h1d);
      chk(ad, 16'h003f);
      issue(op_displaced_load, PTR_SECOND, MODE_PLAIN, 16'h003e, 8'h0c);
      chk(rf, 8'h1d);
      chk(o_ptr_second, 16'h0001);
      issue(op_direct_store, 2'h0, 2'h0, 16'h1234, 8'h69);
      chk(ad, 16'h1234);
      issue(op_direct_load, 2'h0, 2'h0, 16'h1234, 8'h11);
      chk(rf, 8'h69);
      chk(16'(cyc), 16'(CYC_DATA));
      $display("offset and direct forms finished");
   endtask : t_offsets
   task t_stack;
      issue(op_push, 2'h0, 2'h0, 16'h0000, 8'ha5);
      chk(ad, SP_RESET);
      chk(wd, 8'ha5);
      chk(o_stack_ptr, SP_RESET - 16'h0001);
      issue(op_pop, 2'h0, 2'h0, 16'h0000, 8'h04);
      chk(rf, 8'ha5);
      chk(o_stack_ptr, SP_RESET);
      $display("stack finished");
   endtask : t_stack
   task t_prog;
      issue(op_program_memory_read, PTR_THIRD, MODE_POST, 16'h0000, 8'h00);
      chk(rf, 8'h3c);
      chk(o_ptr_third, 16'h0001);
      chk(16'(cyc), 16'(CYC_PROG));
      issue(op_program_memory_read, PTR_THIRD, MODE_PLAIN, 16'h0000, 8'h09);
      chk(rf, 8'h3d);
      chk(ridx, 5'h09);
      issue(op_program_memory_read, PTR_THIRD, MODE_PLAIN, 16'h0000, 8'h00);
      chk(rf, 8'h3d);
      chk(ridx, REG_ZERO);
      $display("program read finished");
   endtask : t_prog
   task t_io_ctrl;
      issue(op_io_out, 2'h0, 2'h0, 16'h002a, 8'h77);
      chk(16'(cyc), 16'(CYC_ONE));
      issue(op_io_in, 2'h0, 2'h0, 16'h002a, 8'h06);
      chk(rf, 8'h77);
      issue(op_sleep, 2'h0, 2'h0, 16'h0000, 8'h00);
      chk(sl, 1'b1);
      issue(op_watchdog_restart, 2'h0, 2'h0, 16'h0000, 8'h00);
      chk(wr, 1'b1);
      issue(op_break, 2'h0, 2'h0, 16'h0000, 8'h00);
      chk(br, 1'b0);
      i_debug_enable = 1'b1;
      issue(op_break, 2'h0, 2'h0, 16'h0000, 8'h00);
      chk(br, 1'b1);
      $display("io and control finished");
   endtask : t_io_ctrl
   task t_pmw;
      // prompt and slow completion from the far side
      for (int d = 0; d < 4; d += 3)
      begin
         wdel = 4'(d);
         i_word_pair = 16'hbe00 + 16'(d);
         issue(op_program_memory_write, PTR_THIRD, MODE_PLAIN, 16'h0000, 8'h00);
         chk(pw, 16'hbe00 + 16'(d));
         chk(16'(cyc), 16'(d + 2));
      end
      $display("program write finished");
   endtask : t_pmw
   ////////////////////////////////////////
   always @(posedge i_sys_clk)
   begin
      tick++;
      if (tick == 1000)
      begin
         n_fail++;
         end_sim;
      end
   end
   initial
   begin
      repeat (10) @(negedge i_sys_clk);
      i_rst_b = 1'b1;
      @(negedge i_sys_clk);
      t_pointers;
      t_offsets;
      t_stack;
      t_prog;
      t_io_ctrl;
      t_pmw;
      end_sim;
   end
endmodule : data_transfer_instruction_unit_test

// ===== tb/mem_model.sv
`timescale 1ns/10ps
module mem_model
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_dm_re,
   input  wire logic        i_dm_we,
   input  wire logic [15:0] i_dm_addr,
   input  wire logic [7:0]  i_dm_wdata,
   output logic      [7:0]  o_dm_rdata,
   input  wire logic        i_pm_re,
   input  wire logic        i_pm_we,
   input  wire logic [15:0] i_pm_addr,
   output logic      [7:0]  o_pm_rdata,
   output logic             o_pm_write_done,
   input  wire logic [3:0]  i_wr_delay,
   input  wire logic        i_io_re,
   input  wire logic        i_io_we,
   input  wire logic [5:0]  i_io_addr,
   input  wire logic [7:0]  i_io_wdata,
   output logic      [7:0]  o_io_rdata
);
   logic [7:0] dm [256];
   logic [7:0] io [64];
   logic [7:0] pq = 8'h00, junk = 8'h00;
   logic       pv = 1'b0;
   logic [3:0] wc = 4'h0;
   // idle buses show a moving pattern so a stale read cannot pass
   always @(posedge i_sys_clk)
   begin
      junk <= junk + 8'h5b;
      if (i_dm_we) dm[i_dm_addr[7:0]] <= i_dm_wdata;
      if (i_io_we) io[i_io_addr] <= i_io_wdata;
      pv <= i_pm_re;
      pq <= i_pm_addr[7:0] ^ 8'h3c;
      wc <= i_pm_we ? wc + 4'h1 : 4'h0;
   end
   assign o_dm_rdata = i_dm_re ? dm[i_dm_addr[7:0]] : junk;
   assign o_pm_rdata = pv ? pq : ~junk;
   assign o_io_rdata = i_io_re ? io[i_io_addr] : junk;
   assign o_pm_write_done = i_pm_we && wc == i_wr_delay;
endmodule : mem_model

// ===== tb/xfer_monitor.sv
`timescale 1ns/10ps
module xfer_monitor
   import xfer_pkg::*;
(
   input wire logic        i_sys_clk,
   input wire logic        i_rst_b,
   input wire logic        i_start,
   input wire xfer_op_e    i_op,
   input wire logic [1:0]  i_ptr_sel,
   input wire logic [1:0]  i_mode,
   input wire logic        i_debug_enable,
   input wire logic [7:0]  i_dm_rdata,
   input wire logic [7:0]  i_pm_rdata,
   input wire logic [7:0]  i_io_rdata,
   input wire logic        o_busy,
   input wire logic        o_done,
   input wire logic        o_rf_we,
   input wire logic [7:0]  o_rf_data,
   input wire logic        o_dm_re,
   input wire logic        o_dm_we,
   input wire logic [15:0] o_dm_addr,
   input wire logic        o_pm_re,
   input wire logic        o_io_re,
   input wire logic        o_io_we,
   input wire logic        o_sleep_req,
   input wire logic        o_watchdog_restart,
   input wire logic        o_break_req,
   input wire logic [15:0] o_ptr_first
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   // a request only counts while the unit is idle
   wire take = i_start && !o_busy;
   ////////////////////////////////////////
   dm_load_a:
      assert property (o_dm_re |=> o_done && o_rf_we && o_rf_data == $past(i_dm_rdata))
      else $error("data load write-back wrong");
   dm_store_a: assert property (o_dm_we |=> o_done && !o_rf_we)
      else $error("store not done after access");
   pm_read_a:
      assert property (o_pm_re |=> !o_done ##1 o_done && o_rf_data == $past(i_pm_rdata))
      else $error("program read timing wrong");
   io_in_a:
      assert property (take && i_op == op_io_in |-> o_io_re ##1 o_done && o_rf_data == $past(i_io_rdata))
      else $error("io input wrong");
   io_out_a: assert property (take && i_op == op_io_out |-> o_io_we ##1 o_done)
      else $error("io output wrong");
   post_inc_a:
      assert property (take && i_op == op_indirect_load && i_mode == MODE_POST && i_ptr_sel == PTR_FIRST
         |=> o_dm_addr == $past(o_ptr_first) ##1 o_ptr_first == $past(o_dm_addr) + 16'h0001)
      else $error("post increment wrong");
   sleep_req_a: assert property (take && i_op == op_sleep |=> o_sleep_req && o_done)
      else $error("sleep pulse missing");
   wdog_pulse_a: assert property (take && i_op == op_watchdog_restart |=> o_watchdog_restart && o_done)
      else $error("watchdog pulse missing");
   break_gate_a: assert property (o_break_req |-> $past(take) && $past(i_debug_enable))
      else $error("break without debug");
   ////////////////////////////////////////
   cover property (take && i_op == op_push);
   cover property (take && i_op == op_program_memory_write);
   cover property (o_break_req);
endmodule : xfer_monitor
////////////////////////////////////////
bind data_transfer_instruction_unit xfer_monitor mon (
   .i_sys_clk, .i_rst_b, .i_start, .i_op, .i_ptr_sel, .i_mode, .i_debug_enable, .i_dm_rdata,
   .i_pm_rdata, .i_io_rdata, .o_busy, .o_done, .o_rf_we, .o_rf_data, .o_dm_re, .o_dm_we,
   .o_dm_addr, .o_pm_re, .o_io_re, .o_io_we, .o_sleep_req, .o_watchdog_restart, .o_break_req,
   .o_ptr_first
);
